// ==== verilog/bdr_pkg.sv ====
// Functional notes
// RULE1: Bit 6 of the dimming configuration register picks the curve, 0 linear (reset) and 1 logarithmic.
// RULE2: In logarithmic mode the table index spans 1023 codes without dithering and 8191 codes with it.
// RULE3: Bit 5 of the dimming configuration register picks analog-only (0, reset) or mixed analog and PWM dimming (1).
// RULE4: Bits 4 to 0 set the per-string current ceiling, code 0 being 2 mA and each step adding 1 mA.
// RULE5: The ceiling code resets to 10010 (20 mA) and code 11111 gives 33 mA.
// RULE6: The string enable register has one bit per string, bit 0 the first and bit 7 the eighth, 1 turning the sink on.
// RULE7: All eight string enable bits are set after reset.
// RULE8: The low brightness register holds the low brightness nibble in bits 7 to 4 and bit 0 is reserved.
// RULE9: The host writes the low brightness register before the high brightness register when it changes the low bits.
// RULE10: A written low nibble stays pending and is applied only at the next register write of any address.
// RULE11: With dithering on, the three dither bits 3 to 1 are appended below the brightness code to form a 15-bit value.
// RULE12: The host updates the dither bits in the same write sequence as the brightness code.
// RULE13: The high brightness register uses all eight bits for the upper code and resets to zero.
// RULE14: Bit 5 of the filter settings register enables dithering and resets to enabled.
// RULE15: The whole brightness value moves into the active dimming path in one clock cycle.
package bdr_pkg;

    // Register offsets
    localparam logic [7:0] BDR_ADDR_BRIGHT_HIGH = 8'h00;
    localparam logic [7:0] BDR_ADDR_DIM_CFG = 8'h03;
    localparam logic [7:0] BDR_ADDR_STRING_EN = 8'h04;
    localparam logic [7:0] BDR_ADDR_BRIGHT_LOW = 8'h05;
    localparam logic [7:0] BDR_ADDR_FILTER = 8'h09;

    // Reset values
    localparam logic [7:0] BDR_RST_BRIGHT_HIGH = 8'h00;
    localparam logic [7:0] BDR_RST_DIM_CFG = 8'h12;
    localparam logic [7:0] BDR_RST_STRING_EN = 8'hFF;
    localparam logic [7:0] BDR_RST_BRIGHT_LOW = 8'h00;
    localparam logic [7:0] BDR_RST_FILTER = 8'h24;

    // Field positions
    localparam int BDR_CFG_LOG_BIT = 6;
    localparam int BDR_CFG_METHOD_BIT = 5;
    localparam int BDR_CFG_MAXI_MSB = 4;
    localparam int BDR_LOW_NIB_MSB = 7;
    localparam int BDR_LOW_NIB_LSB = 4;
    localparam int BDR_LOW_DITH_MSB = 3;
    localparam int BDR_LOW_DITH_LSB = 1;
    localparam int BDR_FILTER_DITHER_BIT = 5;

    // Widths and spans
    localparam int BDR_CODE_W = 12;
    localparam int BDR_DITH_W = 3;
    localparam int BDR_DIM_W = 15;
    localparam int BDR_LUT_W = 13;
    localparam int BDR_MAXI_W = 5;
    localparam logic [12:0] BDR_LOG_SPAN_PLAIN = 13'h03FF;
    localparam logic [12:0] BDR_LOG_SPAN_DITHER = 13'h1FFF;
    localparam logic [5:0] BDR_MAXI_BASE_MA = 6'h02;

    // Serial byte framing
    localparam logic [3:0] BDR_BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        BDR_IDLE = 4'b0000,
        BDR_DEV_ADR = 4'b0001,
        BDR_DEV_ACK = 4'b0010,
        BDR_PTR = 4'b0011,
        BDR_PTR_ACK = 4'b0100,
        BDR_WDATA = 4'b0101,
        BDR_WDATA_ACK = 4'b0110,
        BDR_RDATA = 4'b0111,
        BDR_RDATA_ACK = 4'b1000
    } bdr_state_t;

endpackage

// ==== verilog/bdr_dim_path.sv ====
`timescale 1ns/100ps
module bdr_dim_path (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Active settings
    input wire logic [bdr_pkg::BDR_CODE_W-1:0] code_i,
    input wire logic [bdr_pkg::BDR_DITH_W-1:0] dither_i,
    input wire logic dither_en_i,
    input wire logic log_mode_i,
    input wire logic [bdr_pkg::BDR_MAXI_W-1:0] maxi_code_i,
    // Dimming path
    output logic [bdr_pkg::BDR_DIM_W-1:0] dim_value_o,
    output logic [bdr_pkg::BDR_LUT_W-1:0] lut_index_o,
    output logic [5:0] max_current_ma_o
);
    import bdr_pkg::*;

    logic [BDR_DIM_W-1:0] dim_w;
    logic [BDR_LUT_W-1:0] lut_w;
    logic [5:0] ma_w;

    assign dim_w = dither_en_i ? {code_i, dither_i} : {code_i, {BDR_DITH_W{1'b0}}}; // RULE11
    // Log table index: 10 bits (0..1023) plain, 13 bits (0..8191) dithered
    assign lut_w = !log_mode_i ? '0 :
                   dither_en_i ? (dim_w[BDR_DIM_W-1:2] & BDR_LOG_SPAN_DITHER) :
                   ({3'h0, code_i[BDR_CODE_W-1:2]} & BDR_LOG_SPAN_PLAIN); // RULE2
    assign ma_w = {1'b0, maxi_code_i} + BDR_MAXI_BASE_MA; // RULE4 RULE5

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dim_value_o <= '0;
            lut_index_o <= '0;
            max_current_ma_o <= {1'b0, BDR_RST_DIM_CFG[BDR_CFG_MAXI_MSB:0]} + BDR_MAXI_BASE_MA; // RULE5
        end else if (ce_i) begin
            dim_value_o <= dim_w;
            lut_index_o <= lut_w;
            max_current_ma_o <= ma_w;
        end
    end

endmodule

// ==== verilog/bdr_regs.sv ====
`timescale 1ns/100ps
module bdr_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h3A // Arbitrary bus address
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Two-wire serial bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Dimming controls
    output logic log_mode_o,
    output logic dim_method_select_o,
    output logic [bdr_pkg::BDR_MAXI_W-1:0] max_current_code_o,
    output logic [5:0] max_current_ma_o,
    output logic [7:0] string_on_mask_o,
    output logic dither_en_o,
    output logic [bdr_pkg::BDR_DIM_W-1:0] dim_value_o,
    output logic [bdr_pkg::BDR_LUT_W-1:0] lut_index_o
);
    import bdr_pkg::*;

    // Bus sampling and framing
    logic scl_q_reg, sda_q_reg, scl_p_reg, sda_p_reg;
    bdr_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic oe_n_reg, oe_n_next;

    // Register bank
    logic [7:0] bright_high_reg, dim_cfg_reg, string_en_reg, bright_low_reg, filter_reg;
    logic pend_reg;
    logic [7:0] act_high_reg;
    logic [3:0] act_nib_reg;
    logic [2:0] act_dith_reg;

    logic scl_rise, scl_fall, start_w, stop_w, byte_full;
    logic wr_w;
    logic [7:0] rdata_w;
    logic sel_high, sel_cfg, sel_en, sel_low, sel_filt;
    logic wr_high, wr_cfg, wr_en, wr_low, wr_filt, commit_w;
    logic [BDR_CODE_W-1:0] act_code_w;

    assign scl_rise = scl_q_reg & ~scl_p_reg;
    assign scl_fall = ~scl_q_reg & scl_p_reg;
    assign start_w = scl_q_reg & scl_p_reg & sda_p_reg & ~sda_q_reg;
    assign stop_w = scl_q_reg & scl_p_reg & ~sda_p_reg & sda_q_reg;
    assign byte_full = (cnt_reg == BDR_BITS_PER_BYTE);

    assign sel_high = (ptr_reg == BDR_ADDR_BRIGHT_HIGH);
    assign sel_cfg = (ptr_reg == BDR_ADDR_DIM_CFG);
    assign sel_en = (ptr_reg == BDR_ADDR_STRING_EN);
    assign sel_low = (ptr_reg == BDR_ADDR_BRIGHT_LOW);
    assign sel_filt = (ptr_reg == BDR_ADDR_FILTER);

    // Write strobe at the falling edge that ends a data byte
    assign wr_w = (state_reg == BDR_WDATA) && scl_fall && byte_full && !start_w && !stop_w;
    assign wr_high = wr_w & sel_high;
    assign wr_cfg = wr_w & sel_cfg;
    assign wr_en = wr_w & sel_en;
    assign wr_low = wr_w & sel_low;
    assign wr_filt = wr_w & sel_filt;
    // Any register write, mapped or not, applies a pending low part
    assign commit_w = wr_w & pend_reg;

    // Active brightness code as seen by the dimming path
    assign act_code_w = {act_high_reg, act_nib_reg};

    // Unmapped offsets read as zero
    assign rdata_w = sel_high ? bright_high_reg :
                     sel_cfg ? dim_cfg_reg :
                     sel_en ? string_en_reg :
                     sel_low ? bright_low_reg :
                     sel_filt ? filter_reg : 8'h00;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        oe_n_next = oe_n_reg;
        if (start_w) begin
            state_next = BDR_DEV_ADR;
            cnt_next = 4'h0;
            oe_n_next = 1'b1;
        end else if (stop_w) begin
            state_next = BDR_IDLE;
            oe_n_next = 1'b1;
        end else if (scl_rise) begin
            unique case (state_reg)
                BDR_DEV_ADR, BDR_PTR, BDR_WDATA: begin
                    if (!byte_full) begin
                        shift_next = {shift_reg[6:0], sda_q_reg};
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                BDR_RDATA: begin
                    cnt_next = cnt_reg + 4'h1;
                end
                BDR_RDATA_ACK: begin
                    cnt_next = {3'h0, sda_q_reg};
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_reg)
                BDR_IDLE: begin
                end
                BDR_DEV_ADR: begin
                    if (byte_full) begin
                        if (shift_reg[7:1] == DEV_ADDR) begin
                            rw_next = shift_reg[0];
                            oe_n_next = 1'b0;
                            state_next = BDR_DEV_ACK;
                        end else begin
                            state_next = BDR_IDLE;
                        end
                    end
                end
                BDR_DEV_ACK: begin
                    cnt_next = 4'h0;
                    if (rw_reg) begin
                        shift_next = rdata_w;
                        oe_n_next = rdata_w[7];
                        state_next = BDR_RDATA;
                    end else begin
                        oe_n_next = 1'b1;
                        state_next = BDR_PTR;
                    end
                end
                BDR_PTR: begin
                    if (byte_full) begin
                        ptr_next = shift_reg;
                        oe_n_next = 1'b0;
                        state_next = BDR_PTR_ACK;
                    end
                end
                BDR_PTR_ACK, BDR_WDATA_ACK: begin
                    oe_n_next = 1'b1;
                    cnt_next = 4'h0;
                    state_next = BDR_WDATA;
                end
                BDR_WDATA: begin
                    if (byte_full) begin
                        ptr_next = ptr_reg + 8'h01;
                        oe_n_next = 1'b0;
                        state_next = BDR_WDATA_ACK;
                    end
                end
                BDR_RDATA: begin
                    if (byte_full) begin
                        ptr_next = ptr_reg + 8'h01;
                        oe_n_next = 1'b1;
                        state_next = BDR_RDATA_ACK;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_n_next = shift_reg[6];
                    end
                end
                BDR_RDATA_ACK: begin
                    if (cnt_reg[0]) begin
                        state_next = BDR_IDLE;
                    end else begin
                        cnt_next = 4'h0;
                        shift_next = rdata_w;
                        oe_n_next = rdata_w[7];
                        state_next = BDR_RDATA;
                    end
                end
                default: begin
                    state_next = BDR_IDLE;
                    oe_n_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            scl_p_reg <= 1'b1;
            sda_p_reg <= 1'b1;
        end else if (ce_i) begin
            scl_q_reg <= scl_i;
            sda_q_reg <= sda_i;
            scl_p_reg <= scl_q_reg;
            sda_p_reg <= sda_q_reg;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= BDR_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else if (ce_i) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // Register writes, one short block per register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bright_high_reg <= BDR_RST_BRIGHT_HIGH; // RULE13
        end else if (ce_i && wr_high) begin
            bright_high_reg <= shift_reg; // RULE13
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dim_cfg_reg <= BDR_RST_DIM_CFG; // RULE1 RULE3 RULE5
        end else if (ce_i && wr_cfg) begin
            dim_cfg_reg <= {1'b0, shift_reg[6:0]}; // RULE1 RULE3 RULE4
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            string_en_reg <= BDR_RST_STRING_EN; // RULE7
        end else if (ce_i && wr_en) begin
            string_en_reg <= shift_reg; // RULE6
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bright_low_reg <= BDR_RST_BRIGHT_LOW;
        end else if (ce_i && wr_low) begin
            bright_low_reg <= {shift_reg[7:1], 1'b0}; // RULE8
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            filter_reg <= BDR_RST_FILTER; // RULE14
        end else if (ce_i && wr_filt) begin
            filter_reg <= shift_reg;
        end
    end

    // Pending low part and the active brightness, all moved on one edge
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
            act_high_reg <= BDR_RST_BRIGHT_HIGH;
            act_nib_reg <= 4'h0;
            act_dith_reg <= 3'h0;
        end else if (ce_i && wr_w) begin
            pend_reg <= sel_low; // RULE10
            if (commit_w) begin
                act_nib_reg <= bright_low_reg[BDR_LOW_NIB_MSB:BDR_LOW_NIB_LSB]; // RULE10 RULE15
                act_dith_reg <= bright_low_reg[BDR_LOW_DITH_MSB:BDR_LOW_DITH_LSB]; // RULE15
            end
            if (sel_high) begin
                act_high_reg <= shift_reg; // RULE15
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
            log_mode_o <= 1'b0;
            dim_method_select_o <= 1'b0;
            max_current_code_o <= BDR_RST_DIM_CFG[BDR_CFG_MAXI_MSB:0];
            string_on_mask_o <= BDR_RST_STRING_EN;
            dither_en_o <= BDR_RST_FILTER[BDR_FILTER_DITHER_BIT];
        end else if (ce_i) begin
            sda_o <= 1'b0;
            sda_oe_n_o <= oe_n_next;
            log_mode_o <= dim_cfg_reg[BDR_CFG_LOG_BIT]; // RULE1
            dim_method_select_o <= dim_cfg_reg[BDR_CFG_METHOD_BIT]; // RULE3
            max_current_code_o <= dim_cfg_reg[BDR_CFG_MAXI_MSB:0]; // RULE4
            string_on_mask_o <= string_en_reg; // RULE6
            dither_en_o <= filter_reg[BDR_FILTER_DITHER_BIT]; // RULE14
        end
    end

    bdr_dim_path u_dim_path (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .code_i(act_code_w),
        .dither_i(act_dith_reg),
        .dither_en_i(filter_reg[BDR_FILTER_DITHER_BIT]),
        .log_mode_i(dim_cfg_reg[BDR_CFG_LOG_BIT]),
        .maxi_code_i(dim_cfg_reg[BDR_CFG_MAXI_MSB:0]),
        .dim_value_o(dim_value_o),
        .lut_index_o(lut_index_o),
        .max_current_ma_o(max_current_ma_o)
    );

endmodule

// ==== verification/bdr_regs_monitor.sv ====
`timescale 1ns/100ps
module bdr_regs_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Serial bus
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    // Dimming controls
    input wire logic log_mode_o,
    input wire logic dim_method_select_o,
    input wire logic [bdr_pkg::BDR_MAXI_W-1:0] max_current_code_o,
    input wire logic [5:0] max_current_ma_o,
    input wire logic [7:0] string_on_mask_o,
    input wire logic dither_en_o,
    input wire logic [bdr_pkg::BDR_DIM_W-1:0] dim_value_o,
    input wire logic [bdr_pkg::BDR_LUT_W-1:0] lut_index_o
);
    import bdr_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_reset_values;
        $fell(rst_i) |-> string_on_mask_o == 8'hFF && max_current_code_o == 5'h12
            && !log_mode_o && !dim_method_select_o && dither_en_o && dim_value_o == '0;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");
    property p_ma_map;
        $stable(max_current_code_o) [*2] |-> max_current_ma_o == max_current_code_o + 6'h02;
    endproperty
    a_ma_map: assert property (p_ma_map) else $error("ceiling mA mismatch");
    property p_linear_lut;
        !log_mode_o [*3] |-> lut_index_o == '0;
    endproperty
    a_linear_lut: assert property (p_linear_lut) else $error("index in linear");
    property p_plain_span;
        (log_mode_o && !dither_en_o) [*3] |-> lut_index_o <= BDR_LOG_SPAN_PLAIN;
    endproperty
    a_plain_span: assert property (p_plain_span) else $error("index over span");
    property p_dither_lut;
        (log_mode_o && dither_en_o && $stable(dim_value_o)) [*3]
            |-> lut_index_o == dim_value_o[14:2];
    endproperty
    a_dither_lut: assert property (p_dither_lut) else $error("dither index wrong");
    property p_no_dither_bits;
        !dither_en_o [*3] |-> dim_value_o[2:0] == 3'h0;
    endproperty
    a_no_dither_bits: assert property (p_no_dither_bits) else $error("dither bits");
    property p_atomic;
        $changed(dim_value_o) && dither_en_o == $past(dither_en_o, 2) |=> $stable(dim_value_o);
    endproperty
    a_atomic: assert property (p_atomic) else $error("value moved in two steps");
    property p_ctrl_on_ack;
        $changed({string_on_mask_o, max_current_code_o, log_mode_o, dim_method_select_o,
            dither_en_o}) |-> !sda_oe_n_o;
    endproperty
    a_ctrl_on_ack: assert property (p_ctrl_on_ack) else $error("change off write");
    property p_dim_on_ack;
        $changed(dim_value_o) |-> !sda_oe_n_o;
    endproperty
    a_dim_on_ack: assert property (p_dim_on_ack) else $error("value change off write");

    c_top_ceiling: cover property (max_current_code_o == 5'h1F);
    c_log_dither: cover property (log_mode_o && dither_en_o && lut_index_o != '0);
    c_commit: cover property ($changed(dim_value_o));
endmodule

bind bdr_regs bdr_regs_monitor u_monitor (
    .core_clk_i, .rst_i, .ce_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .log_mode_o,
    .dim_method_select_o, .max_current_code_o, .max_current_ma_o, .string_on_mask_o,
    .dither_en_o, .dim_value_o, .lut_index_o
);

// ==== verification/bdr_host_model.sv ====
`timescale 1ns/100ps
module bdr_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h3A
) (
    // Clock and wire level
    input wire logic clk_i,
    input wire logic sda_i,
    // Host drive
    output logic scl_o,
    output logic sda_pull_o
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Low and high phases of four clocks each, data moved only while clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o = ~b;
        hold(3);
        scl_o = 1'b1;
        hold(4);
        r = sda_i;
        scl_o = 1'b0;
        hold(1);
    endtask
    task automatic start();
        sda_pull_o = 1'b0;
        hold(3);
        scl_o = 1'b1;
        hold(4);
        sda_pull_o = 1'b1;
        hold(4);
        scl_o = 1'b0;
        hold(1);
    endtask
    task automatic stop();
        sda_pull_o = 1'b1;
        hold(3);
        scl_o = 1'b1;
        hold(4);
        sda_pull_o = 1'b0;
        hold(4);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic nb, output logic [7:0] q,
                           output logic r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(nb, r);
    endtask
    task automatic wr(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] d,
                      output logic nack);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        byte_io({adr, 1'b0}, 1'b1, q, a0);
        byte_io(ptr, 1'b1, q, a1);
        byte_io(d, 1'b1, q, a2);
        stop();
        nack = a0 | a1 | a2;
    endtask
    task automatic wr2(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
                       output logic nack);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(ptr, 1'b1, q, a1);
        byte_io(d0, 1'b1, q, a2);
        byte_io(d1, 1'b1, q, a3);
        stop();
        nack = a0 | a1 | a2 | a3;
    endtask
    // Master acknowledge after the first byte reads on at the next offset
    task automatic rd2(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
        logic a;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, d0, a);
        byte_io(ptr, 1'b1, d0, a);
        start();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, d0, a);
        byte_io(8'hFF, 1'b0, d0, a);
        byte_io(8'hFF, 1'b1, d1, a);
        stop();
    endtask
    // Last byte is refused with a release so the device ends the read
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic a;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, d, a);
        byte_io(ptr, 1'b1, d, a);
        start();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, d, a);
        byte_io(8'hFF, 1'b1, d, a);
        stop();
    endtask
endmodule

// ==== verification/backlight_dimming_registers_tb_top.sv ====
`timescale 1ns/100ps
module backlight_dimming_registers_tb_top;
    import bdr_pkg::*;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [21:0] outs;
    } bdr_row_t;
    localparam logic [6:0] DEV = 7'h3A;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic scl, sda_pull, sda_out, sda_oe_n, log_mode, meth, dith_en, nack;
    logic [4:0] code;
    logic [5:0] ma;
    logic [7:0] mask, rd, rd_b;
    logic [14:0] dim;
    logic [12:0] lut;
    int n_mismatch = 0;
    int cmp_count = 0;
    // Released wire has a pull-up
    wire sda_w = !(sda_pull || (!sda_oe_n && !sda_out));
    wire [21:0] obs = {dith_en, log_mode, meth, code, ma, mask};
    logic [7:0] rst_ptr [5] = '{BDR_ADDR_BRIGHT_HIGH, BDR_ADDR_DIM_CFG, BDR_ADDR_STRING_EN,
        BDR_ADDR_BRIGHT_LOW, BDR_ADDR_FILTER};
    logic [7:0] rst_val [5] = '{8'h00, 8'h12, 8'hFF, 8'h00, 8'h24};
    bdr_row_t rows [6] = '{
        '{8'h03, 8'h5F, 8'h5F, {3'b110, 5'h1F, 6'h21, 8'hFF}},
        '{8'h03, 8'hA0, 8'h20, {3'b101, 5'h00, 6'h02, 8'hFF}},
        '{8'h04, 8'h5A, 8'h5A, {3'b101, 5'h00, 6'h02, 8'h5A}},
        '{8'h0C, 8'h77, 8'h00, {3'b101, 5'h00, 6'h02, 8'h5A}},
        '{8'h09, 8'h00, 8'h00, {3'b001, 5'h00, 6'h02, 8'h5A}},
        '{8'h09, 8'h24, 8'h24, {3'b101, 5'h00, 6'h02, 8'h5A}}};

    always #25 clk = ~clk;

    bdr_regs #(.DEV_ADDR(DEV)) dut (
        .core_clk_i(clk), .rst_i(rst), .ce_i(ce), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_out), .sda_oe_n_o(sda_oe_n), .log_mode_o(log_mode),
        .dim_method_select_o(meth), .max_current_code_o(code), .max_current_ma_o(ma),
        .string_on_mask_o(mask), .dither_en_o(dith_en), .dim_value_o(dim),
        .lut_index_o(lut)
    );
    bdr_host_model #(.DEV_ADDR(DEV)) host (
        .clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull)
    );

    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_out(input logic [22:0] got, input logic [22:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check_out({1'b0, obs}, {4'b0100, 5'h12, 6'h14, 8'hFF});
        check_out({8'h00, dim}, 23'h0);
        foreach (rst_ptr[i]) begin
            host.rd(rst_ptr[i], rd);
            check_rd(rd, rst_val[i]);
        end
        foreach (rows[i]) begin
            host.wr(DEV, rows[i].ptr, rows[i].wdata, nack);
            host.rd(rows[i].ptr, rd);
            check_rd(rd, rows[i].rdata);
            check_out({nack, obs}, {1'b0, rows[i].outs});
        end
        // Low part held until the next write, reserved bit dropped
        host.wr(DEV, BDR_ADDR_BRIGHT_LOW, 8'hA5, nack);
        check_out({8'h00, dim}, 23'h0);
        host.wr(DEV, BDR_ADDR_BRIGHT_HIGH, 8'h12, nack);
        check_out({8'h00, dim}, 23'h0952);
        host.rd(BDR_ADDR_BRIGHT_LOW, rd);
        check_rd(rd, 8'hA4);
        host.wr(DEV, BDR_ADDR_BRIGHT_LOW, 8'h3E, nack);
        host.wr(DEV, BDR_ADDR_STRING_EN, 8'hFF, nack);
        check_out({8'h00, dim}, 23'h091F);
        host.wr(DEV, BDR_ADDR_BRIGHT_LOW, 8'h50, nack);
        host.wr(DEV, BDR_ADDR_BRIGHT_LOW, 8'h60, nack);
        check_out({8'h00, dim}, 23'h0928);
        host.wr(DEV, BDR_ADDR_DIM_CFG, 8'h52, nack);
        check_out({10'h0, lut}, 23'h024C);
        host.wr(DEV, BDR_ADDR_FILTER, 8'h00, nack);
        check_out({10'h0, lut}, 23'h0049);
        // Read burst: master acknowledge moves on to the next offset
        host.rd2(BDR_ADDR_STRING_EN, rd, rd_b);
        check_rd(rd, 8'hFF);
        check_rd(rd_b, 8'h60);
        // Clock enable low: a whole write goes unseen
        ce = 1'b0;
        host.wr(DEV, BDR_ADDR_STRING_EN, 8'h00, nack);
        ce = 1'b1;
        check_out({nack, 14'h0, mask}, {1'b1, 14'h0, 8'hFF});
        // Foreign bus address is ignored
        host.wr(7'h3B, BDR_ADDR_STRING_EN, 8'h00, nack);
        check_out({nack, 14'h0, mask}, {1'b1, 14'h0, 8'hFF});
        // Write burst: the pointer steps on to the low brightness register
        host.wr2(BDR_ADDR_STRING_EN, 8'hC3, 8'h70, nack);
        check_out({nack, 14'h0, mask}, {1'b0, 14'h0, 8'hC3});
        check_out({8'h00, dim}, 23'h0930);
        host.rd(BDR_ADDR_BRIGHT_LOW, rd);
        check_rd(rd, 8'h70);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check_out({dim, mask}, {15'h0, 8'hFF});
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
